/* File: hw/cers_exec_unit.sv */
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "cers_map.svh"

// Operation
// RQ1 - return pops stack into pc, two cycles
// RQ2 - rotate right through carry, d picks destination
// RQ3 - low power clears watchdog, prescaler, then halts
// RQ4 - low power clears power-down, sets timeout
// RQ5 - literal minus w into w, c dc z
// RQ6 - file minus w, d picks destination
// RQ7 - swap nibbles, d picks destination, no flags
// RQ8 - w xor literal into w, updates zero
// RQ9 - w xor file, d picks destination
// RQ10 - return with literal loads w, pops pc
// RQ11 - zero flag set when result is zero
module cers_exec_unit #(
	parameter int STACK_DEPTH = 8,
	parameter int PC_W = 13
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// instruction port
	input wire logic inst_valid_in,
	input wire cers_pkg::cers_op_t inst_op_in,
	input wire logic [7:0] inst_operand_in,
	input wire logic inst_dest_in,
	output logic busy_out,
	output logic done_out,
	// wake pin
	input wire logic wake_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// core state
	output logic [7:0] w_out,
	output logic carry_flag_out,
	output logic digit_carry_flag_out,
	output logic zero_flag_out,
	output logic power_down_flag_out,
	output logic timeout_flag_out,
	output logic [PC_W-1:0] pc_out,
	output logic [7:0] watchdog_counter_out,
	output logic sleeping_out
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	typedef struct packed {
		cers_pkg::cers_state_t state;
		cers_pkg::cers_op_t op;
		logic [7:0] lit;
		logic dest;
		logic [7:0] w;
		logic c;
		logic dc;
		logic z;
		logic pwr_dn;
		logic to;
		logic [PC_W-1:0] pc;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [SP_W-1:0] sp;
		logic [7:0] wdog;
		logic [7:0] pre;
		logic [6:0] view_addr;
		logic [7:0] view;
		logic [7:0] rdata;
		logic busy;
		logic done;
		logic sleeping;
		logic wake_meta;
		logic wake_sync;
	} cers_core_t;

	cers_core_t q;
	cers_core_t next_q;
	logic [1:0] rst_sync;
	logic rst_n;
	logic mem_we;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [PC_W-1:0] stack_top_entry;

	// ==========================================================
	// reset release
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ==========================================================
	// file registers
	cers_file_mem #(.DEPTH(128), .AW(7)) u_cers_file_mem (
		.clock_in(clock_in),
		.reset_n_in(rst_n),
		.write_en_in(mem_we),
		.addr_in(mem_addr),
		.write_data_in(mem_wdata),
		.read_data_out(mem_rdata)
	);

	assign stack_top_entry = q.stack[q.sp - SP_W'(1)];

	// ==========================================================
	// sequencer and datapath
	always_comb begin
		logic [7:0] src;
		logic [8:0] diff;
		logic [4:0] ndiff;
		logic [7:0] res;
		logic lit_op;
		src = 8'h00;
		diff = 9'h000;
		ndiff = 5'h00;
		res = 8'h00;
		lit_op = 1'b0;
		next_q = q;
		next_q.done = 1'b0;
		next_q.wake_meta = wake_in;
		next_q.wake_sync = q.wake_meta;
		next_q.pre = q.pre + 8'h01;
		if (&q.pre) begin
			next_q.wdog = q.wdog + 8'h01;
		end
		mem_we = 1'b0;
		mem_addr = q.view_addr;
		mem_wdata = reg_wdata_in;
		if (reg_read_in) begin
			case (reg_addr_in)
				`CERS_OFF_W: next_q.rdata = q.w;
				`CERS_OFF_STATUS: next_q.rdata =
					{3'h0, q.to, q.pwr_dn, q.z, q.dc, q.c};
				`CERS_OFF_PC_LO: next_q.rdata = q.pc[7:0];
				`CERS_OFF_PC_HI: next_q.rdata = 8'(q.pc[PC_W-1:8]);
				`CERS_OFF_WDOG: next_q.rdata = q.wdog;
				`CERS_OFF_FILE_ADDR: next_q.rdata = {1'b0, q.view_addr};
				`CERS_OFF_FILE_DATA: next_q.rdata = q.view;
				default: next_q.rdata = 8'h00;
			endcase
		end
		case (q.state)
			cers_pkg::st_idle: begin
				next_q.view = mem_rdata;
				if (inst_valid_in) begin
					next_q.op = inst_op_in;
					next_q.lit = inst_operand_in;
					next_q.dest = inst_dest_in;
					next_q.state = cers_pkg::st_exec;
					next_q.busy = 1'b1;
					mem_addr = inst_operand_in[6:0];
				end else if (reg_write_in) begin
					case (reg_addr_in)
						`CERS_OFF_W: next_q.w = reg_wdata_in;
						`CERS_OFF_STATUS: begin
							next_q.c = reg_wdata_in[`CERS_BIT_C];
							next_q.dc = reg_wdata_in[`CERS_BIT_DC];
							next_q.z = reg_wdata_in[`CERS_BIT_Z];
						end
						`CERS_OFF_PC_LO: next_q.pc[7:0] = reg_wdata_in;
						`CERS_OFF_PC_HI: next_q.pc[PC_W-1:8] = reg_wdata_in[PC_W-9:0];
						`CERS_OFF_PUSH: begin
							next_q.stack[q.sp] = q.pc;
							next_q.sp = q.sp + SP_W'(1);
						end
						`CERS_OFF_FILE_ADDR: next_q.view_addr = reg_wdata_in[6:0];
						`CERS_OFF_FILE_DATA: mem_we = 1'b1;
						default: next_q.view_addr = q.view_addr;
					endcase
				end
			end
			cers_pkg::st_exec: begin
				lit_op = (q.op == cers_pkg::op_subtract_from_literal) ||
					(q.op == cers_pkg::op_exclusive_or_literal);
				src = lit_op ? q.lit : mem_rdata;
				diff = {1'b0, src} + {1'b0, ~q.w} + 9'h001;
				ndiff = {1'b0, src[3:0]} + {1'b0, ~q.w[3:0]} + 5'h01;
				next_q.state = cers_pkg::st_idle;
				next_q.busy = 1'b0;
				next_q.done = 1'b1;
				case (q.op)
					cers_pkg::op_return,
					cers_pkg::op_return_with_literal: begin
						if (q.op == cers_pkg::op_return_with_literal) begin
							next_q.w = q.lit; // [RQ10]
						end
						next_q.pc = stack_top_entry; // [RQ1] [RQ10]
						next_q.sp = q.sp - SP_W'(1);
						next_q.state = cers_pkg::st_ret2;
						next_q.busy = 1'b1;
						next_q.done = 1'b0;
					end
					cers_pkg::op_rotate_right_thru_carry: begin
						res = {q.c, src[7:1]}; // [RQ2]
						next_q.c = src[0];
					end
					cers_pkg::op_low_power: begin
						next_q.wdog = 8'h00; // [RQ3]
						next_q.pre = 8'h00;
						next_q.pwr_dn = 1'b0; // [RQ4]
						next_q.to = 1'b1;
						next_q.state = cers_pkg::st_sleep;
						next_q.busy = 1'b1;
						next_q.done = 1'b0;
					end
					cers_pkg::op_subtract_from_literal,
					cers_pkg::op_subtract_register: begin
						res = diff[7:0]; // [RQ5] [RQ6]
						next_q.c = diff[8];
						next_q.dc = ndiff[4];
						next_q.z = (diff[7:0] == 8'h00); // [RQ11]
					end
					cers_pkg::op_nibble_swap: res = {src[3:0], src[7:4]}; // [RQ7]
					cers_pkg::op_exclusive_or_literal,
					cers_pkg::op_exclusive_or_register: begin
						res = q.w ^ src; // [RQ8] [RQ9]
						next_q.z = (res == 8'h00); // [RQ11]
					end
					default: res = q.w;
				endcase
				if (q.state == cers_pkg::st_exec && !next_q.busy) begin
					if (q.dest && !lit_op) begin
						mem_we = 1'b1; // [RQ2] [RQ6] [RQ7] [RQ9]
						mem_addr = q.lit[6:0];
						mem_wdata = res;
					end else begin
						next_q.w = res;
					end
				end
			end
			cers_pkg::st_ret2: begin
				next_q.state = cers_pkg::st_idle; // [RQ1]
				next_q.busy = 1'b0;
				next_q.done = 1'b1;
			end
			cers_pkg::st_sleep: begin
				if (q.wake_sync) begin
					next_q.state = cers_pkg::st_idle; // [RQ3]
					next_q.busy = 1'b0;
					next_q.done = 1'b1;
				end
			end
			default: next_q.state = cers_pkg::st_idle;
		endcase
		next_q.sleeping = (next_q.state == cers_pkg::st_sleep);
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.w <= `CERS_RST_W;
			q.pwr_dn <= `CERS_RST_PWR_DN;
			q.to <= `CERS_RST_TO;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	assign busy_out = q.busy;
	assign done_out = q.done;
	assign reg_rdata_out = q.rdata;
	assign w_out = q.w;
	assign carry_flag_out = q.c;
	assign digit_carry_flag_out = q.dc;
	assign zero_flag_out = q.z;
	assign power_down_flag_out = q.pwr_dn;
	assign timeout_flag_out = q.to;
	assign pc_out = q.pc;
	assign watchdog_counter_out = q.wdog;
	assign sleeping_out = q.sleeping;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n);

	logic ex;
	assign ex = (q.state == cers_pkg::st_exec);

	a_return_pops_pc: assert property ( // [RQ1]
		ex && q.op == cers_pkg::op_return |=>
		pc_out == $past(stack_top_entry) && busy_out ##1
		done_out && !busy_out && $stable({carry_flag_out, zero_flag_out}))
		else $error("return did not pop pc in two cycles");
	a_rotate_carry: assert property ( // [RQ2]
		ex && q.op == cers_pkg::op_rotate_right_thru_carry |=>
		carry_flag_out == $past(mem_rdata[0]) && $stable(zero_flag_out))
		else $error("rotate carry wrong");
	a_sleep_watchdog_clear: assert property ( // [RQ3]
		ex && q.op == cers_pkg::op_low_power |=>
		watchdog_counter_out == 8'h00 && q.pre == 8'h00 && sleeping_out)
		else $error("low power did not clear watchdog");
	a_sleep_flag_update: assert property ( // [RQ4]
		ex && q.op == cers_pkg::op_low_power |=>
		!power_down_flag_out && timeout_flag_out)
		else $error("low power flags wrong");
	a_sub_literal_value: assert property ( // [RQ5]
		ex && q.op == cers_pkg::op_subtract_from_literal |=>
		w_out == 8'($past(q.lit) - $past(q.w)) &&
		carry_flag_out == ($past(q.lit) >= $past(q.w)))
		else $error("literal subtract wrong");
	a_sub_reg_carry: assert property ( // [RQ6]
		ex && q.op == cers_pkg::op_subtract_register |=>
		carry_flag_out == ($past(mem_rdata) >= $past(q.w)) &&
		digit_carry_flag_out == ($past(mem_rdata[3:0]) >= $past(q.w[3:0])))
		else $error("register subtract flags wrong");
	a_swap_to_w: assert property ( // [RQ7]
		ex && q.op == cers_pkg::op_nibble_swap && !q.dest |=>
		w_out == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} &&
		$stable({carry_flag_out, digit_carry_flag_out, zero_flag_out}))
		else $error("swap wrong");
	a_xor_lit_zero: assert property ( // [RQ8] [RQ11]
		ex && q.op == cers_pkg::op_exclusive_or_literal |=>
		w_out == ($past(q.w) ^ $past(q.lit)) && zero_flag_out == (w_out == 8'h00))
		else $error("literal xor wrong");
	a_xor_reg_file: assert property ( // [RQ9]
		ex && q.op == cers_pkg::op_exclusive_or_register && q.dest |->
		mem_we && mem_wdata == (q.w ^ mem_rdata) && mem_addr == q.lit[6:0])
		else $error("register xor writeback wrong");
	a_return_literal_load: assert property ( // [RQ10]
		ex && q.op == cers_pkg::op_return_with_literal |=>
		w_out == $past(q.lit) && pc_out == $past(stack_top_entry) ##1 done_out)
		else $error("return with literal wrong");

	c_return: cover property (ex && q.op == cers_pkg::op_return ##2 done_out);
	c_sleep_wake: cover property (sleeping_out ##1 !sleeping_out && done_out);
	c_sub_zero: cover property (
		ex && q.op == cers_pkg::op_subtract_register ##1 zero_flag_out);

endmodule : cers_exec_unit

/* File: inc/cers_map.svh */
`ifndef CERS_MAP_SVH
`define CERS_MAP_SVH

// ==========================================================
// register offsets
`define CERS_OFF_W 4'h0
`define CERS_OFF_STATUS 4'h1
`define CERS_OFF_PC_LO 4'h2
`define CERS_OFF_PC_HI 4'h3
`define CERS_OFF_PUSH 4'h4
`define CERS_OFF_WDOG 4'h5
`define CERS_OFF_FILE_ADDR 4'h6
`define CERS_OFF_FILE_DATA 4'h7

// ==========================================================
// status field positions
`define CERS_BIT_C 0
`define CERS_BIT_DC 1
`define CERS_BIT_Z 2
`define CERS_BIT_PWR_DN 3
`define CERS_BIT_TO 4

// ==========================================================
// reset values
`define CERS_RST_W 8'h00
`define CERS_RST_PWR_DN 1'b1
`define CERS_RST_TO 1'b1

`endif

/* File: inc/cers_pkg.sv */
package cers_pkg;

	// ==========================================================
	// operation select
	typedef enum logic [3:0] {
		op_return = 4'b0000,
		op_return_with_literal = 4'b0001,
		op_rotate_right_thru_carry = 4'b0010,
		op_low_power = 4'b0011,
		op_subtract_from_literal = 4'b0100,
		op_subtract_register = 4'b0101,
		op_nibble_swap = 4'b0110,
		op_exclusive_or_literal = 4'b0111,
		op_exclusive_or_register = 4'b1000
	} cers_op_t;

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_exec = 3'b001,
		st_ret2 = 3'b010,
		st_sleep = 3'b011
	} cers_state_t;

endpackage : cers_pkg

/* File: hw/cers_file_mem.sv */
`timescale 1ns/1ps

module cers_file_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// access port
	input wire logic write_en_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] write_data_in,
	output logic [7:0] read_data_out
);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rdata;
	} cers_mem_t;

	cers_mem_t q;
	cers_mem_t next_q;

	// ==========================================================
	// registered read, old data on write
	always_comb begin
		next_q = q;
		next_q.rdata = q.mem[addr_in];
		if (write_en_in) begin
			next_q.mem[addr_in] = write_data_in;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign read_data_out = q.rdata;

endmodule : cers_file_mem

/* File: verif/tb_cers_exec_unit.sv */
`timescale 1ns/1ps
`include "cers_map.svh"

module tb_cers_exec_unit;

	// ==========================================================
	// signals
	logic clock_in;
	logic reset_n_in;
	logic inst_valid;
	logic inst_dest;
	logic wake;
	logic reg_write;
	logic reg_read;
	cers_pkg::cers_op_t inst_op;
	logic [7:0] inst_operand;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] w_val;
	logic [7:0] wdog_count;
	logic [3:0] reg_addr;
	logic busy;
	logic done;
	logic c_f;
	logic dc_f;
	logic z_f;
	logic pwr_dn_f;
	logic to_f;
	logic sleeping;
	logic [12:0] pc;
	int errors;
	int total_checks;

	// ==========================================================
	// design
	cers_exec_unit u_cers_exec_unit (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.inst_valid_in(inst_valid), .inst_op_in(inst_op),
		.inst_operand_in(inst_operand), .inst_dest_in(inst_dest),
		.busy_out(busy), .done_out(done), .wake_in(wake),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_write_in(reg_write), .reg_read_in(reg_read),
		.reg_rdata_out(reg_rdata), .w_out(w_val),
		.carry_flag_out(c_f), .digit_carry_flag_out(dc_f),
		.zero_flag_out(z_f), .power_down_flag_out(pwr_dn_f),
		.timeout_flag_out(to_f), .pc_out(pc),
		.watchdog_counter_out(wdog_count), .sleeping_out(sleeping)
	);

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	// ==========================================================
	// tasks
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock_in);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_in);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock_in);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_rd

	task automatic file_wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr(`CERS_OFF_FILE_ADDR, a);
		reg_wr(`CERS_OFF_FILE_DATA, d);
	endtask : file_wr

	task automatic file_rd(input logic [7:0] a, output logic [7:0] d);
		reg_wr(`CERS_OFF_FILE_ADDR, a);
		repeat (3) @(posedge clock_in);
		reg_rd(`CERS_OFF_FILE_DATA, d);
	endtask : file_rd

	task automatic wait_done(output int n);
		for (n = 1; n < 40; n++) begin
			@(posedge clock_in);
			#1;
			if (done === 1'b1)
				break;
		end
		if (n >= 40) begin
			errors++;
			test_done();
		end
	endtask : wait_done

	task automatic exec(input cers_pkg::cers_op_t op, input logic [7:0] k,
		input logic d, output int n);
		@(posedge clock_in);
		inst_valid <= 1'b1;
		inst_op <= op;
		inst_operand <= k;
		inst_dest <= d;
		@(posedge clock_in);
		inst_valid <= 1'b0;
		wait_done(n);
	endtask : exec

	// ==========================================================
	// sequence
	initial begin
		logic [7:0] kv [3];
		logic [7:0] wv [3];
		logic [7:0] r;
		logic [7:0] e;
		int n;
		kv = '{8'h10, 8'h05, 8'h20};
		wv = '{8'h10, 8'h06, 8'h01};
		errors = 0;
		total_checks = 0;
		reset_n_in = 1'b0;
		inst_valid = 1'b0;
		inst_op = cers_pkg::op_return;
		inst_operand = 8'h00;
		inst_dest = 1'b0;
		wake = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (5) @(posedge clock_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		// reset state and unmapped read
		chk("w", w_val, `CERS_RST_W);
		chk("pd to", {pwr_dn_f, to_f}, {`CERS_RST_PWR_DN, `CERS_RST_TO});
		reg_rd(4'h9, r);
		chk("unmapped", r, 8'h00);
		reg_rd(`CERS_OFF_STATUS, r);
		chk("status", r, 8'h18);
		// literal minus w
		for (int i = 0; i < 3; i++) begin
			reg_wr(`CERS_OFF_W, wv[i]);
			exec(cers_pkg::op_subtract_from_literal, kv[i], 1'b1, n);
			e = kv[i] - wv[i];
			chk("sub w", w_val, e);
			chk("sub flags", {c_f, dc_f, z_f}, {kv[i] >= wv[i],
				kv[i][3:0] >= wv[i][3:0], e == 8'h00});
			chk("cycles", 16'(n), 16'h0001);
		end
		// file minus w
		file_wr(8'h05, 8'h33);
		reg_wr(`CERS_OFF_W, 8'h40);
		exec(cers_pkg::op_subtract_register, 8'h05, 1'b0, n);
		chk("subf w", w_val, 8'hf3);
		chk("subf flags", {c_f, dc_f, z_f}, 3'b010);
		exec(cers_pkg::op_subtract_register, 8'h05, 1'b1, n);
		file_rd(8'h05, r);
		chk("subf file", r, 8'h40);
		chk("subf keep w", w_val, 8'hf3);
		// rotate right through carry, zero kept
		reg_wr(`CERS_OFF_STATUS, 8'h04);
		file_wr(8'h0a, 8'h03);
		exec(cers_pkg::op_rotate_right_thru_carry, 8'h0a, 1'b0, n);
		chk("rrf w", w_val, 8'h01);
		chk("rrf flags", {c_f, dc_f, z_f}, 3'b101);
		exec(cers_pkg::op_rotate_right_thru_carry, 8'h0a, 1'b1, n);
		file_rd(8'h0a, r);
		chk("rrf file", r, 8'h81);
		chk("rrf keep w", w_val, 8'h01);
		// nibble swap, flags untouched
		file_wr(8'h0b, 8'ha5);
		exec(cers_pkg::op_nibble_swap, 8'h0b, 1'b0, n);
		chk("swap w", w_val, 8'h5a);
		chk("swap flags", {c_f, dc_f, z_f}, 3'b101);
		exec(cers_pkg::op_nibble_swap, 8'h0b, 1'b1, n);
		file_rd(8'h0b, r);
		chk("swap file", r, 8'h5a);
		// exclusive or
		exec(cers_pkg::op_exclusive_or_literal, 8'h5a, 1'b0, n);
		chk("xorl", {w_val, 7'h00, z_f}, 16'h0001);
		exec(cers_pkg::op_exclusive_or_literal, 8'hc3, 1'b0, n);
		chk("xorl", {w_val, 7'h00, z_f}, 16'hc300);
		exec(cers_pkg::op_exclusive_or_register, 8'h0b, 1'b1, n);
		file_rd(8'h0b, r);
		chk("xorf file", r, 8'h99);
		chk("xorf keep w", w_val, 8'hc3);
		exec(cers_pkg::op_exclusive_or_register, 8'h0b, 1'b0, n);
		chk("xorf w", w_val, 8'h5a);
		// returns pop in reverse order
		reg_wr(`CERS_OFF_PC_LO, 8'h34);
		reg_wr(`CERS_OFF_PC_HI, 8'h12);
		reg_wr(`CERS_OFF_PUSH, 8'h00);
		reg_wr(`CERS_OFF_PC_LO, 8'h78);
		reg_wr(`CERS_OFF_PC_HI, 8'h05);
		reg_wr(`CERS_OFF_PUSH, 8'h00);
		reg_wr(`CERS_OFF_PC_LO, 8'h00);
		exec(cers_pkg::op_return, 8'h00, 1'b0, n);
		chk("ret pc", {3'h0, pc}, 16'h0578);
		chk("ret cycles", 16'(n), 16'h0002);
		chk("ret flags", {c_f, dc_f, z_f}, 3'b100);
		exec(cers_pkg::op_return_with_literal, 8'h77, 1'b0, n);
		chk("retl pc", {3'h0, pc}, 16'h1234);
		chk("retl w", w_val, 8'h77);
		chk("retl cycles", 16'(n), 16'h0002);
		// low power after a watchdog step
		r = wdog_count;
		for (n = 0; n < 600 && wdog_count === r; n++) begin
			@(posedge clock_in);
			#1;
		end
		if (n >= 600) begin
			errors++;
			test_done();
		end
		repeat (200) @(posedge clock_in);
		@(posedge clock_in);
		inst_valid <= 1'b1;
		inst_op <= cers_pkg::op_low_power;
		@(posedge clock_in);
		inst_valid <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		chk("sleep", {sleeping, pwr_dn_f, to_f}, 3'b101);
		chk("watchdog clear", wdog_count, 8'h00);
		repeat (250) @(posedge clock_in);
		#1;
		chk("prescaler clear", wdog_count, 8'h00);
		chk("halted", {sleeping, busy}, 2'b11);
		@(posedge clock_in);
		wake <= 1'b1;
		wait_done(n);
		wake <= 1'b0;
		chk("woken", sleeping, 1'b0);
		test_done();
	end

endmodule : tb_cers_exec_unit
